// ### verilog/ld_config_bank.v
// configuration register bank reached through an index port and a data port
// assumes host cycles already qualified as single-cycle strobes on i_clk;
// i_irq8_req, i_sirq_slave_req and i_kbc_disable pass the two-stage synchronisers here
`timescale 1ns/10ps
`include "ld_config_map.vh"

// Behaviour
// - clock codes 010/011/100 give 16/24/48 MHz
// - bits 6:4 select clock; 000, 001 low rates
// - oscillator bit 7 sets interrupt-eight polarity
// - polarity also drives serial IRQ8 frame level
// - flash strobe width five, four, three clocks
// - mode bit 2 blocks slave-started serial cycles
// - mode bits 4:3 pick parallel floppy mode
// - mode bits 7:5 read zero, ignore writes
// - unimplemented indices ignore writes, read zero
// - one bank per logical device, chosen by number
// - index port chooses register for data port
// - device bank only in configuration state, except keyboard indices 0x82-0x9A
// - index 0x30 bit 0 activates selected device
// - base address high 0x60, low 0x61
// - 0x70 everywhere, 0x72 only keyboard controller
// - interrupts default active-high edge after reset
// - 0x74 only floppy and parallel; 0x75 absent
// - device on needs activate, power, disable bits
// - activate and power bits are coupled
// - disable bits 7,6,4 override devices 3,4,0
// - base outside permitted range makes accesses invalid
module ld_config_bank (
    input wire i_clk,
    input wire i_srst,
    input wire i_config_state,
    input wire i_index_wr,
    input wire i_data_wr,
    input wire i_data_rd,
    input wire [7:0] i_wdata,
    input wire [7:0] i_kbc_disable,
    input wire i_irq8_req,
    input wire i_flash_start,
    input wire i_flash_write,
    input wire i_sirq_slave_req,
    input wire [2:0] i_dev_sel,
    output reg [7:0] o_rdata,
    output reg [7:0] o_index,
    output wire o_interrupt_eight_pin,
    output wire o_sirq_irq8_level,
    output wire o_sirq_slave_start,
    output reg o_flash_read_strobe,
    output reg o_flash_write_strobe,
    output wire [2:0] o_clk_sel,
    output wire o_parallel_floppy_mode_one,
    output wire o_parallel_floppy_mode_two,
    output wire [7:0] o_dev_on,
    output wire o_sel_access_valid,
    output wire [15:0] o_sel_io_base,
    output wire [7:0] o_sel_irq,
    output wire [7:0] o_sel_dma
);

reg [7:0] ldn;
reg [7:0] osc;
reg [7:0] dev_mode;
reg [7:0] test_reg [0:2];
reg [7:0] activate;
reg [7:0] base_hi [0:7];
reg [7:0] base_lo [0:7];
reg [7:0] irq_pri [0:7];
reg [7:0] irq_sec;
reg [7:0] dma_sel [0:7];
reg [2:0] flash_cnt;
reg irq8_meta;
reg irq8_sync;
reg sirq_meta;
reg sirq_sync;
reg [7:0] kbc_meta;
reg [7:0] kbc_sync;
reg [7:0] next_rdata;
integer i;

wire [2:0] cur = ldn[2:0];
wire ld_window = (o_index >= `IDX_ACTIVATE);
wire open_mode = (cur == `LDN_KEYBOARD) && (o_index >= `IDX_OPEN_FIRST) &&
    (o_index <= `IDX_OPEN_LAST);
wire ld_reach = i_config_state || open_mode;
wire chip_reach = i_config_state;

////////////////////////////////////////////////////////////////////////////////

function has_base;
    input [2:0] d;
    begin
        has_base = (d == `LDN_FLOPPY) || (d == `LDN_PARALLEL) ||
            (d == `LDN_SERIAL1) || (d == 3'h5);
    end
endfunction

function has_dma;
    input [2:0] d;
    begin
        has_dma = (d == `LDN_FLOPPY) || (d == `LDN_PARALLEL);
    end
endfunction

function exists;
    input [2:0] d;
    begin
        exists = (d != 3'h1) && (d != 3'h2);
    end
endfunction

// override bit from the keyboard controller's disable register
function kbc_gate;
    input [2:0] d;
    input [7:0] dis;
    begin
        case (d)
            `LDN_PARALLEL: kbc_gate = dis[7];
            `LDN_SERIAL1: kbc_gate = dis[6];
            `LDN_FLOPPY: kbc_gate = dis[4];
            default: kbc_gate = 1'b1;
        endcase
    end
endfunction

// base must lie inside the device's range on its boundary
function base_ok;
    input [2:0] d;
    input [15:0] b;
    begin
        if (!has_base(d))
            base_ok = 1'b1;
        else if (d == `LDN_PARALLEL)
            base_ok = (b >= `BASE_MIN) && (b <= 16'h0FFC) && (b[1:0] == 2'h0);
        else
            base_ok = (b >= `BASE_MIN) && (b <= `BASE_MAX) && (b[2:0] == 3'h0);
    end
endfunction

function [2:0] flash_width;
    input [1:0] code;
    begin
        case (code)
            2'h0: flash_width = `FLASH_W00;
            2'h1: flash_width = `FLASH_W01;
            2'h2: flash_width = `FLASH_W10;
            default: flash_width = `FLASH_W10;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// synchronisers

always @(posedge i_clk) begin
    if (i_srst) begin
        irq8_meta <= 1'b0;
        irq8_sync <= 1'b0;
        sirq_meta <= 1'b0;
        sirq_sync <= 1'b0;
        kbc_meta <= 8'hFF;
        kbc_sync <= 8'hFF;
    end else begin
        irq8_meta <= i_irq8_req;
        irq8_sync <= irq8_meta;
        sirq_meta <= i_sirq_slave_req;
        sirq_sync <= sirq_meta;
        kbc_meta <= i_kbc_disable;
        kbc_sync <= kbc_meta;
    end
end

////////////////////////////////////////////////////////////////////////////////
// index and register writes

always @(posedge i_clk) begin
    if (i_srst) begin
        o_index <= 8'h00;
        ldn <= 8'h00;
        osc <= `RST_OSC;
        dev_mode <= `RST_MODE;
        activate <= 8'h00;
        irq_sec <= `RST_IRQ;
        for (i = 0; i < 3; i = i + 1) begin
            test_reg[i] <= 8'h00;
        end
        for (i = 0; i < 8; i = i + 1) begin
            base_hi[i] <= `RST_BASE;
            base_lo[i] <= `RST_BASE;
            irq_pri[i] <= `RST_IRQ;
            dma_sel[i] <= `RST_DMA;
        end
    end else if (i_index_wr) begin
        o_index <= i_wdata;
    end else if (i_data_wr) begin
        if (!ld_window && chip_reach) begin
            case (o_index)
                `IDX_LDN: ldn <= i_wdata;
                `IDX_OSC: osc <= i_wdata;
                `IDX_DEVICE_MODE: dev_mode <= i_wdata & `MODE_WRITE_MASK;
                `IDX_TEST_ONE: test_reg[0] <= i_wdata;
                `IDX_TEST_TWO: test_reg[1] <= i_wdata;
                `IDX_TEST_THREE: test_reg[2] <= i_wdata;
                default: ;
            endcase
        end else if (ld_window && ld_reach && exists(cur)) begin
            case (o_index)
                // one bit stands for both activate and power control
                `IDX_ACTIVATE: activate[cur] <= i_wdata[0];
                `IDX_IO_BASE_HI: if (has_base(cur)) base_hi[cur] <= i_wdata;
                `IDX_IO_BASE_LO: if (has_base(cur)) base_lo[cur] <= i_wdata;
                `IDX_IRQ_PRIMARY: irq_pri[cur] <= i_wdata;
                `IDX_IRQ_SECONDARY:
                    if (cur == `LDN_KEYBOARD) irq_sec <= i_wdata;
                `IDX_DMA_SELECT: if (has_dma(cur)) dma_sel[cur] <= i_wdata;
                default: ;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// read path

always @* begin
    next_rdata = 8'h00;
    if (!ld_window && chip_reach) begin
        case (o_index)
            `IDX_LDN: next_rdata = ldn;
            `IDX_OSC: next_rdata = osc;
            `IDX_DEVICE_MODE: next_rdata = {3'h0, dev_mode[4:0]};
            `IDX_TEST_ONE: next_rdata = test_reg[0];
            `IDX_TEST_TWO: next_rdata = test_reg[1];
            `IDX_TEST_THREE: next_rdata = test_reg[2];
            default: next_rdata = 8'h00;
        endcase
    end else if (ld_window && ld_reach && exists(cur)) begin
        case (o_index)
            `IDX_ACTIVATE: next_rdata = {7'h00, activate[cur]};
            `IDX_IO_BASE_HI:
                next_rdata = has_base(cur) ? base_hi[cur] : 8'h00;
            `IDX_IO_BASE_LO:
                next_rdata = has_base(cur) ? base_lo[cur] : 8'h00;
            `IDX_IRQ_PRIMARY: next_rdata = irq_pri[cur];
            `IDX_IRQ_SECONDARY:
                next_rdata = (cur == `LDN_KEYBOARD) ? irq_sec : 8'h00;
            `IDX_DMA_SELECT:
                next_rdata = has_dma(cur) ? dma_sel[cur] : 8'h00;
            default: next_rdata = 8'h00;
        endcase
    end
end

always @(posedge i_clk) begin
    if (i_srst) begin
        o_rdata <= 8'h00;
    end else if (i_data_rd) begin
        o_rdata <= next_rdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// flash strobe timing

always @(posedge i_clk) begin
    if (i_srst) begin
        flash_cnt <= 3'h0;
        o_flash_read_strobe <= 1'b0;
        o_flash_write_strobe <= 1'b0;
    end else if (flash_cnt != 3'h0) begin
        flash_cnt <= flash_cnt - 3'h1;
        if (flash_cnt == 3'h1) begin
            o_flash_read_strobe <= 1'b0;
            o_flash_write_strobe <= 1'b0;
        end
    end else if (i_flash_start) begin
        flash_cnt <= flash_width(dev_mode[`MODE_FLASH_MSB:`MODE_FLASH_LSB]);
        o_flash_read_strobe <= !i_flash_write;
        o_flash_write_strobe <= i_flash_write;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign o_clk_sel = osc[`OSC_CLK_MSB:`OSC_CLK_LSB];
assign o_interrupt_eight_pin = irq8_sync ^ osc[`OSC_POL_BIT];
assign o_sirq_irq8_level = irq8_sync ^ osc[`OSC_POL_BIT];
assign o_sirq_slave_start = sirq_sync && !dev_mode[`MODE_SIRQ_BIT];
assign o_parallel_floppy_mode_one =
    (dev_mode[`MODE_PPFD_MSB:`MODE_PPFD_LSB] == `PPFD_ONE);
assign o_parallel_floppy_mode_two =
    (dev_mode[`MODE_PPFD_MSB:`MODE_PPFD_LSB] == `PPFD_TWO);

genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : dev_gate
        localparam [2:0] DEV = g;
        assign o_dev_on[g] = activate[g] &&
            kbc_gate(DEV, kbc_sync);
    end
endgenerate

assign o_sel_io_base = {base_hi[i_dev_sel], base_lo[i_dev_sel]};
assign o_sel_access_valid = o_dev_on[i_dev_sel] &&
    base_ok(i_dev_sel, o_sel_io_base);
assign o_sel_irq = irq_pri[i_dev_sel];
assign o_sel_dma = has_dma(i_dev_sel) ? dma_sel[i_dev_sel] : 8'h00;

endmodule // ld_config_bank

// ### verilog/ld_config_map.vh
// constants of the plug-and-play configuration bank: indices, fields,
// reset values and strobe widths; included by the bank module only
`ifndef LD_CONFIG_MAP_VH
`define LD_CONFIG_MAP_VH

`define IDX_LDN 8'h07
`define IDX_OSC 8'h24
`define IDX_DEVICE_MODE 8'h25
`define IDX_CHIP_VENDOR 8'h26
`define IDX_TEST_FIRST 8'h27
`define IDX_TEST_ZERO 8'h2C
`define IDX_TEST_ONE 8'h2D
`define IDX_TEST_TWO 8'h2E
`define IDX_TEST_THREE 8'h2F
`define IDX_ACTIVATE 8'h30
`define IDX_IO_BASE_HI 8'h60
`define IDX_IO_BASE_LO 8'h61
`define IDX_IRQ_PRIMARY 8'h70
`define IDX_IRQ_SECONDARY 8'h72
`define IDX_DMA_SELECT 8'h74
`define IDX_OPEN_FIRST 8'h82
`define IDX_OPEN_LAST 8'h9A

`define LDN_FLOPPY 3'h0
`define LDN_PARALLEL 3'h3
`define LDN_SERIAL1 3'h4
`define LDN_KEYBOARD 3'h7

`define OSC_POL_BIT 7
`define OSC_CLK_MSB 6
`define OSC_CLK_LSB 4
`define MODE_FLASH_MSB 1
`define MODE_FLASH_LSB 0
`define MODE_SIRQ_BIT 2
`define MODE_PPFD_MSB 4
`define MODE_PPFD_LSB 3
`define MODE_WRITE_MASK 8'h1F

`define CLK_SEL_1M8 3'h0
`define CLK_SEL_14M3 3'h1
`define CLK_SEL_16M 3'h2
`define CLK_SEL_24M 3'h3
`define CLK_SEL_48M 3'h4

`define PPFD_NORMAL 2'h0
`define PPFD_ONE 2'h1
`define PPFD_TWO 2'h2

`define FLASH_W00 3'h5
`define FLASH_W01 3'h4
`define FLASH_W10 3'h3

`define RST_OSC 8'h00
`define RST_MODE 8'h00
`define RST_IRQ 8'h00
`define RST_DMA 8'h04
`define RST_BASE 8'h00
`define BASE_MIN 16'h0100
`define BASE_MAX 16'h0FF8

`endif

// ### bench/ld_config_bank_props.sv
// checker on the configuration bank ports
// assumes one clock and the synchronous reset of the bank
`timescale 1ns/10ps
module ld_config_bank_props (
    input wire i_clk,
    input wire i_srst,
    input wire i_config_state,
    input wire i_index_wr,
    input wire i_data_rd,
    input wire [7:0] i_wdata,
    input wire [7:0] i_kbc_disable,
    input wire i_flash_start,
    input wire i_flash_write,
    input wire i_sirq_slave_req,
    input wire [2:0] i_dev_sel,
    input wire [7:0] o_rdata,
    input wire [7:0] o_index,
    input wire o_interrupt_eight_pin,
    input wire o_sirq_irq8_level,
    input wire o_sirq_slave_start,
    input wire o_flash_read_strobe,
    input wire o_flash_write_strobe,
    input wire o_parallel_floppy_mode_one,
    input wire o_parallel_floppy_mode_two,
    input wire [7:0] o_dev_on,
    input wire o_sel_access_valid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    wire rd = i_data_rd && !i_index_wr;
    wire busy = o_flash_read_strobe || o_flash_write_strobe;
    index_take_a:
        assert property (i_index_wr |=> o_index == $past(i_wdata))
        else $error("index not taken");
    mode_zero_a:
        assert property (rd && i_config_state && o_index == 8'h25
            |=> o_rdata[7:5] == 3'h0) else $error("mode top bits set");
    hole_read_a:
        assert property (rd && (o_index == 8'h26 || o_index == 8'h75)
            |=> o_rdata == 8'h00) else $error("hole read nonzero");
    floppy_mode_a:
        assert property (!(o_parallel_floppy_mode_one &&
            o_parallel_floppy_mode_two)) else $error("two floppy modes");
    irq8_mirror_a:
        assert property (o_interrupt_eight_pin == o_sirq_irq8_level)
        else $error("frame level differs from pin");
    sirq_source_a:
        assert property (o_sirq_slave_start |-> $past(i_sirq_slave_req, 2))
        else $error("slave start without request");
    read_width_a:
        assert property ($rose(o_flash_read_strobe) |->
            o_flash_read_strobe [*3] ##[1:3] !o_flash_read_strobe)
        else $error("read strobe width");
    write_width_a:
        assert property ($rose(o_flash_write_strobe) |->
            o_flash_write_strobe [*3] ##[1:3] !o_flash_write_strobe)
        else $error("write strobe width");
    strobe_start_a:
        assert property (i_flash_start && !busy && !i_flash_write
            |=> o_flash_read_strobe) else $error("read strobe late");
    kbc_force_a:
        assert property (!$past(i_kbc_disable[4]) &&
            !$past(i_kbc_disable[4], 2) |-> !o_dev_on[0])
        else $error("override ignored");
    valid_on_a:
        assert property (o_sel_access_valid |-> o_dev_on[i_dev_sel])
        else $error("valid while off");
    cover property ($rose(o_flash_read_strobe));
    cover property ($rose(o_flash_write_strobe));
    cover property (o_sel_access_valid);
endmodule // ld_config_bank_props
bind ld_config_bank ld_config_bank_props i_ld_config_bank_props (.*);

// ### bench/host_model.sv
// host side of the index and data ports
// assumes the bank takes strobes at the rising clock edge
`timescale 1ns/10ps
module host_model (
    input wire i_clk,
    input wire [7:0] i_rdata,
    output reg o_index_wr,
    output reg o_data_wr,
    output reg o_data_rd,
    output reg [7:0] o_wdata
);
    initial begin
        o_index_wr = 1'b0;
        o_data_wr = 1'b0;
        o_data_rd = 1'b0;
        o_wdata = 8'h00;
    end
    task sel(input [7:0] idx);
        begin
            @(posedge i_clk);
            o_index_wr <= 1'b1;
            o_wdata <= idx;
            @(posedge i_clk);
            o_index_wr <= 1'b0;
        end
    endtask
    task put(input [7:0] idx, input [7:0] val);
        begin
            if (idx < 8'h27 || idx > 8'h2F) begin
                sel(idx);
                o_data_wr <= 1'b1;
                o_wdata <= val;
                @(posedge i_clk);
                o_data_wr <= 1'b0;
                o_wdata <= ~val;
                @(negedge i_clk);
            end
        end
    endtask
    task get(input [7:0] idx, output [7:0] val);
        begin
            sel(idx);
            o_data_rd <= 1'b1;
            @(posedge i_clk);
            o_data_rd <= 1'b0;
            @(negedge i_clk);
            val = i_rdata;
        end
    endtask
endmodule // host_model

// ### bench/ld_config_bank_bench.sv
// self-checking bench of the configuration bank
// assumes the host model and the bound checker
`timescale 1ns/10ps
module ld_config_bank_bench;
    reg i_clk = 1'b0;
    reg i_srst = 1'b1;
    reg cfg = 1'b1;
    reg [7:0] kbc = 8'hFF;
    reg irq8 = 1'b1;
    reg fs = 1'b0;
    reg fw = 1'b0;
    reg sreq = 1'b0;
    reg [2:0] dsel = 3'h0;
    wire iw, dw, dr, pin8, lvl8, sstart, frd, fwr, pp1, pp2, valid;
    wire [7:0] wd, rdata, on, sirq_sel, sdma_sel;
    wire [2:0] csel;
    wire [15:0] base;
    integer n_fail = 0;
    integer cmp_count = 0;
    integer i, n;
    reg [7:0] d;
    reg [39:0] holes = 40'h26_31_71_75_DF;
    always #12.5 i_clk = ~i_clk;
    ld_config_bank i_ld_config_bank (.i_clk(i_clk), .i_srst(i_srst),
        .i_config_state(cfg), .i_index_wr(iw), .i_data_wr(dw),
        .i_data_rd(dr), .i_wdata(wd), .i_kbc_disable(kbc),
        .i_irq8_req(irq8), .i_flash_start(fs), .i_flash_write(fw),
        .i_sirq_slave_req(sreq), .i_dev_sel(dsel), .o_rdata(rdata),
        .o_index(), .o_interrupt_eight_pin(pin8),
        .o_sirq_irq8_level(lvl8), .o_sirq_slave_start(sstart),
        .o_flash_read_strobe(frd), .o_flash_write_strobe(fwr),
        .o_clk_sel(csel), .o_parallel_floppy_mode_one(pp1),
        .o_parallel_floppy_mode_two(pp2), .o_dev_on(on),
        .o_sel_access_valid(valid), .o_sel_io_base(base),
        .o_sel_irq(sirq_sel), .o_sel_dma(sdma_sel));
    host_model i_host_model (.i_clk(i_clk), .i_rdata(rdata),
        .o_index_wr(iw), .o_data_wr(dw), .o_data_rd(dr), .o_wdata(wd));
    ////////////////////////////////////////////////////////////////////
    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("[ERR] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task w(input [7:0] a, input [7:0] v);
        i_host_model.put(a, v);
    endtask
    task rdchk(input [7:0] a, input [7:0] e);
        begin
            i_host_model.get(a, d);
            chk("rdata", {8'h00, e}, {8'h00, d});
        end
    endtask
    task end_sim;
        begin
            $display("compares %0d mismatches %0d", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_dev;
        begin
            w(8'h07, 8'h00);
            chk("sel_irq", 16'h0000, {8'h00, sirq_sel});
            chk("sel_dma", 16'h0004, {8'h00, sdma_sel});
            w(8'h70, 8'h06);
            chk("sel_irq", 16'h0006, {8'h00, sirq_sel});
            w(8'h30, 8'h01);
            w(8'h60, 8'h03);
            w(8'h61, 8'hF0);
            rdchk(8'h30, 8'h01);
            chk("dev_on", 16'h0001, {8'h00, on});
            chk("base", 16'h03F0, base);
            chk("valid", 16'h0001, {15'h0, valid});
            w(8'h60, 8'h00);
            chk("valid", 16'h0000, {15'h0, valid});
            w(8'h60, 8'h03);
            @(posedge i_clk);
            kbc <= 8'hEF;
            repeat (3) @(negedge i_clk);
            chk("dev_on", 16'h0000, {8'h00, on});
            @(posedge i_clk);
            kbc <= 8'hFF;
        end
    endtask
    task t_bank;
        begin
            w(8'h07, 8'h03);
            rdchk(8'h30, 8'h00);
            rdchk(8'h74, 8'h04);
            w(8'h72, 8'h05);
            rdchk(8'h72, 8'h00);
            for (i = 0; i < 5; i = i + 1) begin
                w(holes[8*i +: 8], 8'hFF);
                rdchk(holes[8*i +: 8], 8'h00);
            end
            w(8'h07, 8'h07);
            w(8'h72, 8'h05);
            rdchk(8'h72, 8'h05);
        end
    endtask
    task t_mode;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                w(8'h25, {3'h7, i[1:0], 1'b0, i[1:0]});
                rdchk(8'h25, {3'h0, i[1:0], 1'b0, i[1:0]});
                chk("ppfd", i[15:0], {14'h0, pp2, pp1});
                @(posedge i_clk);
                fs <= 1'b1;
                fw <= i[0];
                @(posedge i_clk);
                fs <= 1'b0;
                n = 0;
                repeat (8) begin
                    @(negedge i_clk);
                    if (frd | fwr)
                        n = n + 1;
                end
                chk("width", 16'h0005 - i[15:0], n[15:0]);
            end
            @(posedge i_clk);
            sreq <= 1'b1;
            w(8'h25, 8'h04);
            chk("sirq", 16'h0000, {15'h0, sstart});
            w(8'h25, 8'h00);
            chk("sirq", 16'h0001, {15'h0, sstart});
        end
    endtask
    task t_osc;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                w(8'h24, {i[0], i[2:0], 4'h0});
                chk("clk_sel", i[15:0], {13'h0, csel});
                chk("pin8", {15'h0, ~i[0]}, {15'h0, pin8});
                chk("lvl8", {15'h0, ~i[0]}, {15'h0, lvl8});
            end
        end
    endtask
    task t_run;
        begin
            @(posedge i_clk);
            cfg <= 1'b0;
            w(8'h30, 8'h01);
            chk("dev_on", 16'h0001, {8'h00, on});
            rdchk(8'h30, 8'h00);
            @(posedge i_clk);
            cfg <= 1'b1;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge i_clk);
        i_srst <= 1'b0;
        t_dev;
        t_bank;
        t_mode;
        t_osc;
        t_run;
        end_sim;
    end
    // tests take well under a thousand cycles
    initial begin
        #200000;
        n_fail = n_fail + 1;
        end_sim;
    end
endmodule // ld_config_bank_bench
